// File: mhf_params.svh
// Offsets, field positions, reset values and constants of the multicast hash filter block.
`ifndef MHF_PARAMS_SVH
`define MHF_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave.
`define MHF_REG_CTRL 5'h00
`define MHF_REG_BASE 5'h04
`define MHF_REG_LIST 5'h08
`define MHF_REG_STAT 5'h0C
`define MHF_REG_HASHL 5'h10
`define MHF_REG_HASHH 5'h14

// Control register bit positions.
`define MHF_CTRL_START 0
`define MHF_CTRL_RESUME 1
`define MHF_CTRL_SOFT_RST 2
`define MHF_CTRL_MULTI_IA 3
`define MHF_CTRL_ALL_MC 4
`define MHF_CTRL_NA_SUSP 5
`define MHF_CTRL_RESET 6'h00

// Action block word offsets and fields.
`define MHF_OFF_CMD 32'h0000_0000
`define MHF_OFF_LINK 32'h0000_0004
`define MHF_OFF_CNT 32'h0000_0008
`define MHF_OFF_LIST 32'h0000_000C
`define MHF_BIT_LAST 31
`define MHF_BIT_HALT 30
`define MHF_BIT_ALERT 29
`define MHF_ACT_HI 18
`define MHF_ACT_LO 16
`define MHF_ACT_MCAST 3'h3
`define MHF_BIT_DONE 15
`define MHF_BIT_OK 13
`define MHF_CNT_W 14
`define MHF_GROUP_BYTES 14'h0006

// Frame check sequence polynomial in reflected form and its preset.
`define MHF_CRC_POLY 32'hEDB8_8320
`define MHF_CRC_INIT 32'hFFFF_FFFF

`endif

// File: mhf_pkg.sv
// Types and shared hash function of the multicast hash filter block.
`include "mhf_params.svh"
package mhf_pkg;

	// Command unit states.
	typedef enum logic [3:0] {
		ST_IDLE, ST_RD_CMD, ST_RD_LINK, ST_RD_CNT, ST_RD_LIST,
		ST_PUSH, ST_WAIT_HASH, ST_WR_STAT, ST_SUSP
	} mhf_state_e;

	// Frame check CRC over six address bytes, first byte in bits 7:0, LSB first.
	function automatic logic [5:0] mhf_crc_hash(input logic [47:0] addr);
		logic [31:0] crc;
		crc = `MHF_CRC_INIT;
		for (int i = 0; i < 48; i++) begin
			crc = (crc[0] ^ addr[i]) ? ((crc >> 1) ^ `MHF_CRC_POLY) : (crc >> 1);
		end
		return crc[7:2];
	endfunction

endpackage

// File: mhf_exec.sv
// Execution machine that rebuilds the 64-bit multicast hash table from list bytes.
`timescale 1ns/10ps
`default_nettype none
module mhf_exec
	import mhf_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic soft_rst_i,
	// Setup request from the command unit.
	input wire logic start_i,
	input wire logic [11:0] groups_i,
	input wire logic byte_valid_i,
	input wire logic [7:0] byte_i,
	// Completion and table.
	output logic done_o,
	output logic [63:0] hash_o
);
	logic [47:0] grp_r;
	logic [2:0] bcnt_r;
	logic [11:0] left_r;
	logic busy_r;
	logic grp_end;
	logic [5:0] idx;

	// A group closes on its sixth byte; stray bytes outside a setup are dropped.
	assign grp_end = busy_r && byte_valid_i && (bcnt_r == 3'h5);
	assign idx = mhf_crc_hash({byte_i, grp_r[47:8]});

	// Byte collection and group counting.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || soft_rst_i) begin
			grp_r <= 48'h0;
			bcnt_r <= 3'h0;
			left_r <= 12'h000;
			busy_r <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				bcnt_r <= 3'h0;
				left_r <= groups_i;
				busy_r <= (groups_i != 12'h000);
				done_o <= (groups_i == 12'h000);
			end else if (busy_r && byte_valid_i) begin
				grp_r <= {byte_i, grp_r[47:8]};
				bcnt_r <= grp_end ? 3'h0 : bcnt_r + 3'h1;
				if (grp_end) begin
					left_r <= left_r - 12'h001;
					if (left_r == 12'h001) begin
						busy_r <= 1'b0;
						done_o <= 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || soft_rst_i) begin
			hash_o <= 64'h0;
		end else if (start_i) begin
			hash_o <= 64'h0;
		end else if (grp_end) begin
			hash_o[idx] <= 1'b1;
		end
	end

	a_zero_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(start_i && groups_i == 12'h000 && !soft_rst_i) |=> (hash_o == 64'h0) && done_o)
		else $error("Empty list did not clear the table.");
	a_group_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(grp_end && !soft_rst_i) |=> hash_o[$past(idx)])
		else $error("Completed group did not set its table bit.");
	a_soft_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		soft_rst_i |=> hash_o == 64'h0)
		else $error("Software reset left table bits set.");
endmodule // mhf_exec
`default_nettype wire

// File: mhf_rx_filter.sv
// Receive address filter that consults the multicast hash table.
`timescale 1ns/10ps
`default_nettype none
module mhf_rx_filter
	import mhf_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Destination address from the receive path, first byte in bits 7:0.
	input wire logic da_valid_i,
	input wire logic [47:0] da_i,
	// Table and options.
	input wire logic [63:0] hash_i,
	input wire logic multi_ia_i,
	input wire logic all_mc_i,
	// Verdict.
	output logic accept_o,
	output logic accept_valid_o
);
	logic hit;

	assign hit = hash_i[mhf_crc_hash(da_i)];

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			accept_o <= 1'b0;
			accept_valid_o <= 1'b0;
		end else begin
			accept_valid_o <= da_valid_i;
			accept_o <= da_valid_i && (da_i[0] ? (all_mc_i || hit) : (multi_ia_i && hit));
		end
	end

	a_all_mc: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(da_valid_i && da_i[0] && all_mc_i) |=> accept_o && accept_valid_o)
		else $error("Multicast frame refused with receive-all set.");
	a_ia_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(da_valid_i && !da_i[0] && !multi_ia_i) |=> !accept_o)
		else $error("Individual frame accepted by hash without option.");
	c_mc_hit: cover property (@(posedge clk_sys_i) da_valid_i && da_i[0] && hit && !all_mc_i);
endmodule // mhf_rx_filter
`default_nettype wire

// File: mhf_top.sv
// Multicast setup command unit with Avalon-MM registers, hash table and receive filter.
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "mhf_params.svh"
module mhf_top
	import mhf_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Avalon-MM register slave.
	input wire logic [4:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Host memory word port.
	output logic mem_req_o,
	output logic mem_we_o,
	output logic [31:0] mem_addr_o,
	output logic [31:0] mem_wdata_o,
	input wire logic [31:0] mem_rdata_i,
	input wire logic mem_ack_i,
	// Receive address check.
	input wire logic rx_da_valid_i,
	input wire logic [47:0] rx_da_i,
	output logic rx_accept_o,
	output logic rx_accept_valid_o,
	// Command unit events.
	output logic unit_idle_event_o,
	output logic unit_not_active_event_o,
	output logic action_done_event_o
);
	mhf_state_e state_r;
	logic [5:0] ctrl_r;
	logic [31:0] base_r;
	logic [31:0] list_r;
	logic start_r;
	logic resume_r;
	logic soft_rst_r;
	logic [31:0] blk_r;
	logic [31:0] cmd_r;
	logic [31:0] link_r;
	logic [31:0] lptr_r;
	logic [31:0] word_r;
	logic [1:0] bsel_r;
	logic [13:0] left_r;
	logic last_ok_r;
	logic push_r;
	logic [7:0] push_byte_r;
	logic exec_start_r;
	logic [11:0] exec_groups_r;
	logic exec_done;
	logic [63:0] hash;
	logic is_mcast;
	logic stat_ack;
	logic [11:0] cnt_groups;
	logic bus_acc;

	// Byte-lane merge for writable words.
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Address of a word within the current action block.
	function automatic logic [31:0] blk_addr(input logic [31:0] blk, input logic [31:0] off);
		return base_r + blk + off;
	endfunction

	assign is_mcast = (cmd_r[`MHF_ACT_HI:`MHF_ACT_LO] == `MHF_ACT_MCAST);
	assign stat_ack = (state_r == ST_WR_STAT) && mem_ack_i;
	// whole groups of the count word on the read data.
	assign cnt_groups = 12'(mem_rdata_i[`MHF_CNT_W-1:0] / `MHF_GROUP_BYTES);
	assign bus_acc = (avs_read_i || avs_write_i) && !avs_waitrequest_o;

	// Slave answers one cycle after it sees a request.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
		end
	end

	// Read data is loaded as the wait is dropped; unmapped offsets read zero.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= 32'h0;
		end else if (avs_read_i && avs_waitrequest_o) begin
			unique case (avs_address_i)
				`MHF_REG_CTRL: avs_readdata_o <= {26'h0, ctrl_r};
				`MHF_REG_BASE: avs_readdata_o <= base_r;
				`MHF_REG_LIST: avs_readdata_o <= list_r;
				`MHF_REG_STAT: avs_readdata_o <= {24'h0, last_ok_r, 3'h0, 4'(state_r)};
				`MHF_REG_HASHL: avs_readdata_o <= hash[31:0];
				`MHF_REG_HASHH: avs_readdata_o <= hash[63:32];
				default: avs_readdata_o <= 32'h0;
			endcase
		end
	end

	// Register writes and one-cycle command strobes.
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_r <= `MHF_CTRL_RESET;
			base_r <= 32'h0;
			list_r <= 32'h0;
			start_r <= 1'b0;
			resume_r <= 1'b0;
			soft_rst_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			resume_r <= 1'b0;
			soft_rst_r <= 1'b0;
			if (bus_acc && avs_write_i) begin
				unique case (avs_address_i)
					`MHF_REG_CTRL: begin
						if (avs_byteenable_i[0]) begin
							ctrl_r <= {avs_writedata_i[5:3], 3'h0};
							start_r <= avs_writedata_i[`MHF_CTRL_START];
							resume_r <= avs_writedata_i[`MHF_CTRL_RESUME];
							soft_rst_r <= avs_writedata_i[`MHF_CTRL_SOFT_RST];
						end
					end
					`MHF_REG_BASE: base_r <= be_merge(base_r, avs_writedata_i, avs_byteenable_i);
					`MHF_REG_LIST: list_r <= be_merge(list_r, avs_writedata_i, avs_byteenable_i);
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || soft_rst_r) begin
			state_r <= ST_IDLE;
			mem_req_o <= 1'b0;
			mem_we_o <= 1'b0;
			mem_addr_o <= 32'h0;
			mem_wdata_o <= 32'h0;
			blk_r <= 32'h0;
			cmd_r <= 32'h0;
			link_r <= 32'h0;
			lptr_r <= 32'h0;
			word_r <= 32'h0;
			bsel_r <= 2'h0;
			left_r <= 14'h0;
			push_r <= 1'b0;
			push_byte_r <= 8'h0;
			exec_start_r <= 1'b0;
			exec_groups_r <= 12'h000;
			last_ok_r <= 1'b0;
		end else begin
			push_r <= 1'b0;
			exec_start_r <= 1'b0;
			unique case (state_r)
				ST_IDLE: begin
					if (start_r) begin
						blk_r <= list_r;
						mem_addr_o <= blk_addr(list_r, `MHF_OFF_CMD);
						mem_req_o <= 1'b1;
						state_r <= ST_RD_CMD;
					end
				end
				ST_RD_CMD: begin
					if (mem_ack_i) begin
						cmd_r <= mem_rdata_i;
						mem_addr_o <= blk_addr(blk_r, `MHF_OFF_LINK);
						state_r <= ST_RD_LINK;
					end
				end
				ST_RD_LINK: begin
					if (mem_ack_i) begin
						link_r <= mem_rdata_i;
						if (is_mcast) begin
							mem_addr_o <= blk_addr(blk_r, `MHF_OFF_CNT);
							state_r <= ST_RD_CNT;
						end else begin
							mem_we_o <= 1'b1;
							mem_addr_o <= blk_addr(blk_r, `MHF_OFF_CMD);
							mem_wdata_o <= {cmd_r[31:16], 1'b1, 15'h0};
							last_ok_r <= 1'b0;
							state_r <= ST_WR_STAT;
						end
					end
				end
				ST_RD_CNT: begin
					if (mem_ack_i) begin
						// latch rounded count and start the list.
						exec_start_r <= 1'b1;
						exec_groups_r <= cnt_groups;
						left_r <= 14'(cnt_groups * `MHF_GROUP_BYTES);
						lptr_r <= `MHF_OFF_LIST;
						mem_addr_o <= blk_addr(blk_r, `MHF_OFF_LIST);
						mem_req_o <= (cnt_groups != 12'h000);
						state_r <= (cnt_groups != 12'h000) ? ST_RD_LIST : ST_WAIT_HASH;
					end
				end
				ST_RD_LIST: begin
					if (mem_ack_i) begin
						word_r <= mem_rdata_i;
						bsel_r <= 2'h0;
						mem_req_o <= 1'b0;
						state_r <= ST_PUSH;
					end
				end
				ST_PUSH: begin
					// one list byte per cycle, lowest address first.
					push_r <= 1'b1;
					push_byte_r <= word_r[{bsel_r, 3'h0} +: 8];
					left_r <= left_r - 14'h1;
					bsel_r <= bsel_r + 2'h1;
					if (left_r == 14'h1) begin
						state_r <= ST_WAIT_HASH;
					end else if (bsel_r == 2'h3) begin
						lptr_r <= lptr_r + 32'h4;
						mem_addr_o <= blk_addr(blk_r, lptr_r + 32'h4);
						mem_req_o <= 1'b1;
						state_r <= ST_RD_LIST;
					end
				end
				ST_WAIT_HASH: begin
					// write status once the table is rebuilt.
					if (exec_done) begin
						mem_req_o <= 1'b1;
						mem_we_o <= 1'b1;
						mem_addr_o <= blk_addr(blk_r, `MHF_OFF_CMD);
						mem_wdata_o <= {cmd_r[31:16], 1'b1, 1'b0, 1'b1, 13'h0};
						last_ok_r <= 1'b1;
						state_r <= ST_WR_STAT;
					end
				end
				ST_WR_STAT: begin
					if (mem_ack_i) begin
						mem_we_o <= 1'b0;
						if (cmd_r[`MHF_BIT_LAST]) begin
							mem_req_o <= 1'b0;
							state_r <= ST_IDLE;
						end else if (cmd_r[`MHF_BIT_HALT]) begin
							mem_req_o <= 1'b0;
							state_r <= ST_SUSP;
						end else begin
							// follow the link relative to the base.
							blk_r <= link_r;
							mem_addr_o <= blk_addr(link_r, `MHF_OFF_CMD);
							state_r <= ST_RD_CMD;
						end
					end
				end
				ST_SUSP: begin
					if (resume_r) begin
						blk_r <= link_r;
						mem_addr_o <= blk_addr(link_r, `MHF_OFF_CMD);
						mem_req_o <= 1'b1;
						state_r <= ST_RD_CMD;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			unit_idle_event_o <= 1'b0;
			unit_not_active_event_o <= 1'b0;
			action_done_event_o <= 1'b0;
		end else begin
			unit_idle_event_o <= stat_ack && cmd_r[`MHF_BIT_LAST];
			unit_not_active_event_o <= stat_ack && (cmd_r[`MHF_BIT_LAST] ||
				(cmd_r[`MHF_BIT_HALT] && ctrl_r[`MHF_CTRL_NA_SUSP]));
			action_done_event_o <= stat_ack && cmd_r[`MHF_BIT_ALERT];
		end
	end

	mhf_exec u_exec (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.soft_rst_i(soft_rst_r),
		.start_i(exec_start_r),
		.groups_i(exec_groups_r),
		.byte_valid_i(push_r),
		.byte_i(push_byte_r),
		.done_o(exec_done),
		.hash_o(hash)
	);

	mhf_rx_filter u_rx (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.da_valid_i(rx_da_valid_i),
		.da_i(rx_da_i),
		.hash_i(hash),
		.multi_ia_i(ctrl_r[`MHF_CTRL_MULTI_IA]),
		.all_mc_i(ctrl_r[`MHF_CTRL_ALL_MC]),
		.accept_o(rx_accept_o),
		.accept_valid_o(rx_accept_valid_o)
	);

	a_last_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(stat_ack && cmd_r[`MHF_BIT_LAST] && !soft_rst_r) |=>
		(state_r == ST_IDLE) && unit_idle_event_o && unit_not_active_event_o)
		else $error("Last block did not idle with event.");
	a_halt_susp: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(stat_ack && !cmd_r[`MHF_BIT_LAST] && cmd_r[`MHF_BIT_HALT] && !soft_rst_r) |=>
		(state_r == ST_SUSP) && (unit_not_active_event_o == ctrl_r[`MHF_CTRL_NA_SUSP]))
		else $error("Halt bit did not suspend correctly.");
	a_done_alert: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		action_done_event_o |-> $past(stat_ack) && $past(cmd_r[`MHF_BIT_ALERT]))
		else $error("Done event without alert bit.");
	a_status_ok: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(mem_req_o && mem_we_o) |-> mem_wdata_o[`MHF_BIT_DONE] &&
		(mem_wdata_o[`MHF_BIT_OK] == is_mcast))
		else $error("Status word done or ok bit wrong.");
	a_link_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(stat_ack && !cmd_r[`MHF_BIT_LAST] && !cmd_r[`MHF_BIT_HALT] && !soft_rst_r) |=>
		(mem_addr_o == base_r + $past(link_r)) && (state_r == ST_RD_CMD))
		else $error("Next block address is not base plus link.");
	a_count_round: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		exec_start_r |-> (left_r == 14'(exec_groups_r * `MHF_GROUP_BYTES)) &&
		($past(mem_rdata_i[13:0]) - left_r < `MHF_GROUP_BYTES))
		else $error("List count not rounded down to whole groups.");
	a_hash_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
		(state_r == ST_WAIT_HASH && !exec_done && !soft_rst_r) |=> !mem_req_o)
		else $error("Status written before hash update finished.");
	c_last: cover property (@(posedge clk_sys_i) stat_ack && cmd_r[`MHF_BIT_LAST]);
	c_halt: cover property (@(posedge clk_sys_i) state_r == ST_SUSP && resume_r);
	c_zero: cover property (@(posedge clk_sys_i) exec_start_r && exec_groups_r == 12'h000);
	c_chain: cover property (@(posedge clk_sys_i) stat_ack && !cmd_r[`MHF_BIT_LAST] &&
		!cmd_r[`MHF_BIT_HALT]);
endmodule // mhf_top
`default_nettype wire

// File: mhf_host_mem.sv
// Host memory model that holds action blocks and answers the device's word requests.
`timescale 1ns/10ps
`default_nettype none
module mhf_host_mem (
	// Clock, reset and answer pace.
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	// Word port from the device.
	input wire logic mem_req_i,
	input wire logic mem_we_i,
	input wire logic [31:0] mem_addr_i,
	input wire logic [31:0] mem_wdata_i,
	output logic [31:0] mem_rdata_o,
	output logic mem_ack_o
);
	logic [31:0] mem [0:255];
	int gap_r;

	// reads and writes alike: each held request is answered once, promptly or after a gap.
	// Read data outside an answer changes every cycle so stale words are never mistaken.
	always @(posedge clk_sys_i) begin
		mem_ack_o <= 1'b0;
		mem_rdata_o <= ~mem_rdata_o;
		if (!rst_n_i) begin
			gap_r <= 0;
			mem_rdata_o <= 32'h5A5A_5A5A;
		end else if (mem_req_i && !mem_ack_o) begin
			if (gap_r != 0) begin
				gap_r <= gap_r - 1;
			end else begin
				mem_ack_o <= 1'b1;
				gap_r <= slow_i ? 3 : 0;
				if (mem_we_i) begin
					mem[mem_addr_i[9:2]] <= mem_wdata_i;
				end else begin
					mem_rdata_o <= mem[mem_addr_i[9:2]];
				end
			end
		end
	end
endmodule // mhf_host_mem
`default_nettype wire

// File: tb_multicast_hash_filter_setup.sv
// Self-checking bench for the multicast setup unit, its hash table and receive filter.
`timescale 1ns/10ps
`default_nettype none
`include "mhf_params.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
	$display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module tb_multicast_hash_filter_setup;
	localparam logic [31:0] BASE = 32'h0000_0100;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [4:0] avs_address_i = 5'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0000_0000;
	logic [31:0] avs_readdata_o, mem_rdata, mem_addr, mem_wdata, rd;
	logic avs_waitrequest_o, mem_req, mem_we, mem_ack, rx_accept_o, rx_accept_valid_o;
	logic ev_idle, ev_na, ev_done;
	logic slow = 1'b0;
	logic rx_da_valid_i = 1'b0;
	logic [47:0] rx_da_i = 48'h0000_0000_0000;
	logic [63:0] exp_hash = 64'h0;
	logic [47:0] hits [$];
	logic [5:0] ctrl_opt = 6'h20;
	int err_count = 0, n_tests = 0, n_idle = 0, n_na = 0, n_done = 0;

	// Clock at 10 MHz.
	initial forever #50 clk_sys_i = ~clk_sys_i;

	mhf_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .mem_req_o(mem_req), .mem_we_o(mem_we),
		.mem_addr_o(mem_addr), .mem_wdata_o(mem_wdata), .mem_rdata_i(mem_rdata),
		.mem_ack_i(mem_ack), .rx_da_valid_i(rx_da_valid_i), .rx_da_i(rx_da_i),
		.rx_accept_o(rx_accept_o), .rx_accept_valid_o(rx_accept_valid_o),
		.unit_idle_event_o(ev_idle), .unit_not_active_event_o(ev_na),
		.action_done_event_o(ev_done));

	mhf_host_mem host (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .slow_i(slow),
		.mem_req_i(mem_req), .mem_we_i(mem_we), .mem_addr_i(mem_addr),
		.mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack));

	// Count event pulses from the command unit.
	always @(posedge clk_sys_i) begin
		if (ev_idle === 1'b1) n_idle++;
		if (ev_na === 1'b1) n_na++;
		if (ev_done === 1'b1) n_done++;
	end

	// Reference hash: reflected frame check CRC, first byte first, LSB first.
	function automatic logic [5:0] ref_hash(input logic [47:0] a);
		logic [31:0] c;
		c = 32'hFFFF_FFFF;
		for (int i = 0; i < 48; i++) begin
			c = (c[0] ^ a[i]) ? ((c >> 1) ^ 32'hEDB8_8320) : (c >> 1);
		end
		return c[7:2];
	endfunction

	// Multicast setup command word; reserved bits stay zero.
	// reserved bits zero.
	function automatic logic [31:0] cw(input logic last, input logic s, input logic i);
		return {last, s, i, 10'h000, 3'h3, 16'h0000};
	endfunction

	// One Avalon-MM transfer, held until waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		@(posedge clk_sys_i);
		while (avs_waitrequest_o !== 1'b0 && n < 20) begin
			@(posedge clk_sys_i);
			n++;
		end
		`CHK(n < 20, 1'b1)
		rd = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask

	// Writes a block with random group addresses and predicts the table it leaves.
	task automatic put_blk(input int a, input logic [31:0] cmd, input logic [31:0] link,
		input int cnt);
		int w;
		logic [47:0] ad;
		w = (BASE + a) / 4;
		host.mem[w] = cmd;
		host.mem[w + 1] = link;
		host.mem[w + 2] = cnt;
		exp_hash = 64'h0;
		hits = {};
		for (int g = 0; g < (cnt + 5) / 6; g++) begin
			ad = {$urandom, $urandom};
			ad[0] = 1'b1;
			for (int j = 0; j < 6; j++) begin
				host.mem[w + 3 + (6 * g + j) / 4][8 * ((6 * g + j) % 4) +: 8] = ad[8 * j +: 8];
			end
			if (g < cnt / 6) begin
				exp_hash[ref_hash(ad)] = 1'b1;
				hits.push_back(ad);
			end
		end
	endtask

	// Writes the control register and waits for the unit to stop.
	task automatic go(input logic [31:0] ctl);
		int t0, n;
		t0 = n_idle + n_na;
		n = 0;
		bus(1'b1, `MHF_REG_CTRL, ctl | ctrl_opt);
		while (n_idle + n_na == t0 && n < 3000) begin
			@(posedge clk_sys_i);
			n++;
		end
		`CHK(n < 3000, 1'b1)
		repeat (2) @(posedge clk_sys_i);
	endtask

	// Reads both table halves and compares them with the prediction.
	task automatic chk_hash;
		logic [31:0] lo;
		bus(1'b0, `MHF_REG_HASHL, 32'h0);
		lo = rd;
		bus(1'b0, `MHF_REG_HASHH, 32'h0);
		`CHK({rd, lo}, exp_hash)
	endtask

	// Presents one destination address and checks the verdict a cycle later.
	task automatic rx_chk(input logic [47:0] da);
		logic hit, want;
		hit = exp_hash[ref_hash(da)];
		want = da[0] ? (ctrl_opt[4] | hit) : (ctrl_opt[3] & hit);
		rx_da_i <= da;
		rx_da_valid_i <= 1'b1;
		@(posedge clk_sys_i);
		rx_da_valid_i <= 1'b0;
		@(posedge clk_sys_i);
		`CHK({rx_accept_valid_o, rx_accept_o}, {1'b1, want})
	endtask

	task automatic complete_run;
		$display("comparisons %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (30000) @(posedge clk_sys_i);
		err_count++;
		complete_run();
	end

	initial begin
		logic [47:0] da;
		void'($urandom(32'h48d2713c));
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		bus(1'b0, `MHF_REG_HASHL, 32'h0);
		`CHK(rd, 32'h0000_0000)
		bus(1'b1, `MHF_REG_BASE, BASE);
		// Chained blocks: the second rounds its count down and ends the list.
		put_blk(0, cw(1'b0, 1'b0, 1'b0), 32'h0000_0040, 18);
		put_blk(32'h40, cw(1'b1, 1'b0, 1'b1), 32'h0, 14);
		bus(1'b1, `MHF_REG_LIST, 32'h0);
		go(32'h1);
		`CHK({n_idle, n_na, n_done}, {32'd1, 32'd1, 32'd1})
		`CHK(host.mem[BASE / 4], cw(1'b0, 1'b0, 1'b0) | 32'h0000_A000)
		`CHK(host.mem[(BASE + 64) / 4], cw(1'b1, 1'b0, 1'b1) | 32'h0000_A000)
		bus(1'b0, `MHF_REG_STAT, 32'h0);
		`CHK(rd[3:0], 4'h0)
		chk_hash();
		// Filter verdicts in all four option settings.
		for (int i = 0; i < 48; i++) begin
			if (i % 12 == 0) begin
				ctrl_opt[4:3] = 2'(i / 12);
				bus(1'b1, `MHF_REG_CTRL, ctrl_opt);
			end
			da = {$urandom, $urandom};
			if (i % 4 == 1) da = hits[(i / 4) % 2];
			while (i % 4 == 3 && (da[0] || !exp_hash[ref_hash(da)])) da = {$urandom, $urandom};
			rx_chk(da);
		end
		// Software reset empties the table; a listed address is then refused.
		ctrl_opt = 6'h20;
		bus(1'b1, `MHF_REG_CTRL, 32'h0000_0024);
		da = hits[0];
		exp_hash = 64'h0;
		repeat (2) @(posedge clk_sys_i);
		chk_hash();
		rx_chk(da);
		// Halt block under slow memory, then resume into a zero-count block.
		slow <= 1'b1;
		put_blk(32'h80, cw(1'b0, 1'b1, 1'b0), 32'h0000_00C0, 12);
		bus(1'b1, `MHF_REG_LIST, 32'h0000_0080);
		go(32'h1);
		bus(1'b0, `MHF_REG_STAT, 32'h0);
		`CHK(rd[3:0], 4'h8)
		`CHK({n_idle, n_na, n_done}, {32'd1, 32'd2, 32'd1})
		chk_hash();
		put_blk(32'hC0, cw(1'b1, 1'b0, 1'b1), 32'h0, 0);
		go(32'h2);
		`CHK({n_idle, n_na, n_done}, {32'd2, 32'd3, 32'd2})
		`CHK(host.mem[(BASE + 128) / 4], cw(1'b0, 1'b1, 1'b0) | 32'h0000_A000)
		chk_hash();
		// An unknown action code ends with the error status and leaves the table alone.
		host.mem[(BASE + 256) / 4] = cw(1'b1, 1'b0, 1'b0) ^ 32'h0001_0000;
		host.mem[(BASE + 260) / 4] = 32'h0000_0000;
		bus(1'b1, `MHF_REG_LIST, 32'h0000_0100);
		go(32'h1);
		`CHK(host.mem[(BASE + 256) / 4], cw(1'b1, 1'b0, 1'b0) ^ 32'h0001_8000)
		`CHK({n_idle, n_na, n_done}, {32'd3, 32'd4, 32'd2})
		chk_hash();
		complete_run();
	end
endmodule // tb_multicast_hash_filter_setup
`default_nettype wire
